// file: core/ssq_top.sv
// serial control port, status and identification registers, calibration sequencing
module ssq_top
    import ssq_pkg::*;
#(
    parameter logic [26:0] PART_ID_CODE = 27'h0001234 // arbitrary value
) (
    input wire logic clk,
    input wire logic resetn,
    input wire logic spi_clk,
    input wire logic spi_data_in,
    input wire logic spi_select_n,
    input wire logic pll_locked,
    input wire logic [4:0] ldo_rampup_ok,
    input wire logic [4:0] ldo_overcurrent,
    input wire logic cal_done,
    input wire logic [1:0] cal_oscillator_choice,
    input wire logic [4:0] cal_subband_setting,
    output logic lock_or_readback_pin_o,
    output logic lock_or_readback_pin_oe,
    output logic ldo_enable,
    output logic core_powerdown,
    output logic cal_start,
    output logic manual_calibration_enable,
    output logic [1:0] oscillator_choice,
    output logic [4:0] subband_setting
);
    // ==========================================================
    // input synchronisers
    localparam int SYNC_W = 22;
    // frame select and calibrator done rest high, so reset loads them high
    // and no false select edge or done level follows reset
    localparam logic [SYNC_W-1:0] SYNC_IDLE = 22'h080080;
    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    logic s_clk;
    logic s_din;
    logic s_sel_n;
    logic s_lock;
    logic [4:0] s_ramp;
    logic [4:0] s_ovc;
    logic s_done;
    logic [1:0] s_osc;
    logic [4:0] s_sub;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            sync1_q <= SYNC_IDLE;
            sync2_q <= SYNC_IDLE;
        end else begin
            sync1_q <= {spi_clk, spi_data_in, spi_select_n, pll_locked, ldo_rampup_ok,
                        ldo_overcurrent, cal_done, cal_oscillator_choice, cal_subband_setting};
            sync2_q <= sync1_q;
        end
    end

    // only the second stage feeds the logic
    assign {s_clk, s_din, s_sel_n, s_lock, s_ramp, s_ovc, s_done, s_osc, s_sub} = sync2_q;

    // ==========================================================
    // serial port state
    logic clk_prev_q;
    logic sel_prev_q;
    logic [31:0] shift_q;
    logic [31:0] shift_d;
    logic [5:0] cnt_q;
    logic [5:0] cnt_d;
    logic rd_active_q;
    logic rd_active_d;
    logic [26:0] rd_shift_q;
    logic [26:0] rd_shift_d;
    logic sdo_q;
    logic sdo_d;
    logic [26:0] regs_q [SSQ_NUM_WR_REGS];
    logic [26:0] regs_d [SSQ_NUM_WR_REGS];
    logic main_wr;
    logic rise;
    logic fall;
    logic [31:0] shift_next;
    logic [3:0] rd_addr;
    logic [3:0] wr_addr;
    logic [26:0] status_word;
    logic [26:0] rd_data;

    // ==========================================================
    // calibration and power state
    ssq_cal_state_type cal_state_q;
    ssq_cal_state_type cal_state_d;
    logic [1:0] osc_q;
    logic [1:0] osc_d;
    logic [4:0] sub_q;
    logic [4:0] sub_d;
    logic cal_start_q;
    logic cal_start_d;
    logic pd_q;
    logic pd_d;
    logic manual_q;
    logic manual_d;
    logic pin_out_q;
    logic pin_out_d;
    logic pin_oe_q;
    logic pin_oe_d;
    logic done_low_q;
    logic done_low_d;

    // edges of the synchronised serial clock, counted only inside a frame
    assign rise = s_clk && !clk_prev_q && !s_sel_n;
    assign fall = !s_clk && clk_prev_q && !s_sel_n;
    assign shift_next = {shift_q[30:0], s_din};
    assign rd_addr = shift_next[3:0];
    assign wr_addr = shift_q[SSQ_ADDR_MSB:SSQ_ADDR_LSB];

    // status word assembled live; reading it changes nothing
    assign status_word = {SSQ_RSVD_ZERO, s_ramp, s_ovc, s_lock, osc_q, sub_q};

    always_comb begin
        rd_data = SSQ_REG_RESET;
        if (rd_addr == SSQ_LOCK_AND_REGULATOR_STATUS) begin
            rd_data = status_word;
        end else if (rd_addr == SSQ_PART_IDENTIFICATION) begin
            rd_data = PART_ID_CODE;
        end else if (rd_addr < SSQ_LOCK_AND_REGULATOR_STATUS) begin
            rd_data = regs_q[rd_addr];
        end
    end

    // ==========================================================
    // serial port next state
    always_comb begin
        shift_d = shift_q;
        cnt_d = cnt_q;
        rd_active_d = rd_active_q;
        rd_shift_d = rd_shift_q;
        sdo_d = sdo_q;
        regs_d = regs_q;
        main_wr = 1'b0;
        if (s_sel_n) begin
            cnt_d = SSQ_CNT_RESET;
            rd_active_d = 1'b0;
            // commit a complete write frame on deselect
            if (!sel_prev_q && cnt_q == SSQ_CNT_FULL && !shift_q[SSQ_RW_BIT]
                && wr_addr < SSQ_LOCK_AND_REGULATOR_STATUS) begin
                regs_d[wr_addr] = shift_q[SSQ_DATA_BITS-1:0];
                main_wr = (wr_addr == SSQ_MAIN_DIVIDER_REGISTER);
            end
        end else if (rise) begin
            shift_d = shift_next;
            if (cnt_q != SSQ_CNT_FULL) begin
                cnt_d = cnt_q + 6'h01;
            end
            // header complete on a read: load the answer
            if (cnt_q == SSQ_CNT_HDR_LAST && shift_next[SSQ_HDR_BITS-1]) begin
                rd_active_d = 1'b1;
                rd_shift_d = rd_data;
            end
        end else if (fall && rd_active_q) begin
            sdo_d = rd_shift_q[SSQ_DATA_BITS-1];
            rd_shift_d = {rd_shift_q[25:0], 1'b0};
        end
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            clk_prev_q <= 1'b0;
            sel_prev_q <= 1'b1;
            shift_q <= '0;
            cnt_q <= SSQ_CNT_RESET;
            rd_active_q <= 1'b0;
            rd_shift_q <= SSQ_REG_RESET;
            sdo_q <= 1'b0;
            for (int i = 0; i < SSQ_NUM_WR_REGS; i++) begin
                regs_q[i] <= SSQ_REG_RESET;
            end
        end else begin
            clk_prev_q <= s_clk;
            sel_prev_q <= s_sel_n;
            shift_q <= shift_d;
            cnt_q <= cnt_d;
            rd_active_q <= rd_active_d;
            rd_shift_q <= rd_shift_d;
            sdo_q <= sdo_d;
            regs_q <= regs_d;
        end
    end

    // ==========================================================
    // calibration, power-down and pin next state
    always_comb begin
        cal_state_d = cal_state_q;
        osc_d = osc_q;
        sub_d = sub_q;
        cal_start_d = 1'b0;
        pd_d = pd_q;
        manual_d = regs_q[SSQ_FRACTION_CONTROL_REGISTER][SSQ_MANUAL_CAL_EN_BIT];
        done_low_d = done_low_q;
        case (cal_state_q)
            SSQ_CAL_IDLE: begin
                if (main_wr) begin
                    pd_d = 1'b0;
                    if (manual_d) begin
                        osc_d = regs_q[SSQ_CALIBRATION_CONTROL_REGISTER]
                                [SSQ_CAL_OSC_MSB:SSQ_CAL_OSC_LSB];
                        sub_d = regs_q[SSQ_CALIBRATION_CONTROL_REGISTER]
                                [SSQ_CAL_SUB_MSB:SSQ_CAL_SUB_LSB];
                    end else begin
                        cal_start_d = 1'b1;
                        cal_state_d = SSQ_CAL_RUN;
                        done_low_d = 1'b0;
                    end
                end
            end
            SSQ_CAL_RUN: begin
                // done must be seen low first: the synchroniser still shows
                // the previous result for a few cycles after the start pulse
                if (!s_done) begin
                    done_low_d = 1'b1;
                end
                if (s_done && done_low_q && !cal_start_q) begin
                    osc_d = s_osc;
                    sub_d = s_sub;
                    cal_state_d = SSQ_CAL_IDLE;
                end
            end
            default: begin
                cal_state_d = SSQ_CAL_IDLE;
            end
        endcase
        // pin carries read data only while a read frame is active
        if (rd_active_d && !regs_q[SSQ_PIN_CONTROL_REGISTER][SSQ_READBACK_DISABLE_BIT]) begin
            pin_out_d = sdo_d;
        end else begin
            pin_out_d = s_lock;
        end
        // open-drain mode drives only the low level
        pin_oe_d = !regs_q[SSQ_PIN_CONTROL_REGISTER][SSQ_PIN_TRISTATE_BIT]
                   && (regs_q[SSQ_PIN_CONTROL_REGISTER][SSQ_PIN_CMOS_MODE_BIT] || !pin_out_d);
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            cal_state_q <= SSQ_CAL_IDLE;
            osc_q <= 2'h0;
            sub_q <= 5'h00;
            cal_start_q <= 1'b0;
            pd_q <= 1'b1;
            manual_q <= 1'b0;
            done_low_q <= 1'b0;
            pin_out_q <= 1'b0;
            pin_oe_q <= 1'b0;
        end else begin
            cal_state_q <= cal_state_d;
            osc_q <= osc_d;
            sub_q <= sub_d;
            cal_start_q <= cal_start_d;
            pd_q <= pd_d;
            manual_q <= manual_d;
            done_low_q <= done_low_d;
            pin_out_q <= pin_out_d;
            pin_oe_q <= pin_oe_d;
        end
    end

    // ==========================================================
    // outputs
    logic ldo_en_q;

    always_ff @(posedge clk) begin
        if (!resetn) begin
            ldo_en_q <= 1'b0;
        end else begin
            ldo_en_q <= 1'b1;
        end
    end

    assign lock_or_readback_pin_o = pin_out_q;
    assign lock_or_readback_pin_oe = pin_oe_q;
    assign ldo_enable = ldo_en_q;
    assign core_powerdown = pd_q;
    assign cal_start = cal_start_q;
    assign manual_calibration_enable = manual_q;
    assign oscillator_choice = osc_q;
    assign subband_setting = sub_q;
endmodule : ssq_top

// file: core/ssq_pkg.sv
// constants for the synthesizer status and start-up sequencer
package ssq_pkg;
    // serial word layout: write/read flag, register address, register contents
    localparam int SSQ_WORD_BITS = 32;
    localparam int SSQ_DATA_BITS = 27;
    localparam int SSQ_RW_BIT = 31;
    localparam int SSQ_ADDR_MSB = 30;
    localparam int SSQ_ADDR_LSB = 27;
    localparam int SSQ_HDR_BITS = 5;
    localparam int SSQ_NUM_WR_REGS = 10;
    // register offsets
    localparam logic [3:0] SSQ_MAIN_DIVIDER_REGISTER = 4'h0;
    localparam logic [3:0] SSQ_FRACTION_CONTROL_REGISTER = 4'h1;
    localparam logic [3:0] SSQ_CALIBRATION_CONTROL_REGISTER = 4'h6;
    localparam logic [3:0] SSQ_PIN_CONTROL_REGISTER = 4'h7;
    localparam logic [3:0] SSQ_TEST_INIT_REGISTER = 4'h9;
    localparam logic [3:0] SSQ_LOCK_AND_REGULATOR_STATUS = 4'hA;
    localparam logic [3:0] SSQ_PART_IDENTIFICATION = 4'hB;
    // status word fields
    localparam int SSQ_ST_RSVD_MSB = 26;
    localparam int SSQ_ST_RSVD_LSB = 18;
    localparam int SSQ_ST_RAMPUP_MSB = 17;
    localparam int SSQ_ST_RAMPUP_LSB = 13;
    localparam int SSQ_ST_OVC_MSB = 12;
    localparam int SSQ_ST_OVC_LSB = 8;
    localparam int SSQ_ST_LOCK_BIT = 7;
    localparam int SSQ_ST_OSC_MSB = 6;
    localparam int SSQ_ST_OSC_LSB = 5;
    localparam int SSQ_ST_SUB_MSB = 4;
    localparam int SSQ_ST_SUB_LSB = 0;
    // control fields
    localparam int SSQ_MANUAL_CAL_EN_BIT = 26;
    localparam int SSQ_CAL_OSC_MSB = 26;
    localparam int SSQ_CAL_OSC_LSB = 25;
    localparam int SSQ_CAL_SUB_MSB = 24;
    localparam int SSQ_CAL_SUB_LSB = 20;
    localparam int SSQ_PIN_TRISTATE_BIT = 25;
    localparam int SSQ_PIN_CMOS_MODE_BIT = 24;
    localparam int SSQ_READBACK_DISABLE_BIT = 23;
    // reset values and frame counter limits
    localparam logic [26:0] SSQ_REG_RESET = 27'h0000000;
    localparam logic [8:0] SSQ_RSVD_ZERO = 9'h000;
    localparam logic [5:0] SSQ_CNT_RESET = 6'h00;
    localparam logic [5:0] SSQ_CNT_HDR_LAST = 6'h04;
    localparam logic [5:0] SSQ_CNT_FULL = 6'h20;
    // oscillator choices and calibration states
    typedef enum logic [1:0] {
        lowest_band_oscillator = 2'h0,
        low_mid_band_oscillator = 2'h1,
        mid_high_band_oscillator = 2'h2,
        highest_band_oscillator = 2'h3
    } ssq_oscillator_choice_type;
    typedef enum {
        SSQ_CAL_IDLE,
        SSQ_CAL_RUN
    } ssq_cal_state_type;
endpackage : ssq_pkg

// file: dv/ssq_top_properties.sv
// assertions on the status and start-up sequencer ports
module ssq_top_properties
    import ssq_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic spi_select_n,
    input wire logic pll_locked,
    input wire logic cal_done,
    input wire logic [1:0] cal_oscillator_choice,
    input wire logic [4:0] cal_subband_setting,
    input wire logic lock_or_readback_pin_oe,
    input wire logic ldo_enable,
    input wire logic core_powerdown,
    input wire logic cal_start,
    input wire logic manual_calibration_enable,
    input wire logic [1:0] oscillator_choice,
    input wire logic [4:0] subband_setting
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    // start pulse, busy three cycles, result offered four
    sequence s_cal_run;
        cal_start ##1 !cal_done [*3] ##1 cal_done [*4];
    endsequence
    AST_RESET_STATE: assert property (
        $rose(resetn) |-> core_powerdown && !ldo_enable && !cal_start)
        else $error("outputs not at reset values");
    AST_LDO_ON: assert property ($past(resetn) |-> ldo_enable)
        else $error("regulators off after reset");
    AST_PD_AFTER_FRAME: assert property (
        $fell(core_powerdown) |-> $past(spi_select_n, 3) && spi_select_n)
        else $error("power-down left outside a write");
    AST_CAL_PULSE: assert property (cal_start |=> !cal_start)
        else $error("calibration start not one cycle");
    AST_CAL_AUTO_ONLY: assert property (cal_start |-> !manual_calibration_enable)
        else $error("calibration started in manual mode");
    AST_CAL_AFTER_FRAME: assert property (
        cal_start |-> !core_powerdown && $past(spi_select_n, 3))
        else $error("calibration start without write");
    AST_CAL_RESULT: assert property (
        s_cal_run |-> oscillator_choice == cal_oscillator_choice
            && subband_setting == cal_subband_setting)
        else $error("calibration result not taken");
    AST_PIN_IDLE: assert property (
        (spi_select_n && $stable(pll_locked)) [*6] |-> lock_or_readback_pin_oe == !pll_locked)
        else $error("pin not showing lock when idle");
endmodule : ssq_top_properties

bind ssq_top ssq_top_properties u_props (.clk(clk), .resetn(resetn),
    .spi_select_n(spi_select_n), .pll_locked(pll_locked), .cal_done(cal_done),
    .cal_oscillator_choice(cal_oscillator_choice), .cal_subband_setting(cal_subband_setting),
    .lock_or_readback_pin_oe(lock_or_readback_pin_oe), .ldo_enable(ldo_enable),
    .core_powerdown(core_powerdown), .cal_start(cal_start),
    .manual_calibration_enable(manual_calibration_enable),
    .oscillator_choice(oscillator_choice), .subband_setting(subband_setting));

// file: dv/ssq_host_model.sv
// host controller model driving the serial control port
module ssq_host_model
    import ssq_pkg::*;
#(
    parameter int HALF = 8
) (
    input wire logic clk,
    input wire logic pin_o,
    input wire logic pin_oe,
    output logic spi_clk,
    output logic spi_data_in,
    output logic spi_select_n
);
    timeunit 1ns;
    timeprecision 1ps;
    logic pin_level;
    // open-drain line with pull-up
    assign pin_level = pin_oe ? pin_o : 1'b1;
    initial begin
        spi_clk = 1'b0;
        spi_data_in = 1'b0;
        spi_select_n = 1'b1;
    end
    task automatic xfer(input logic [31:0] word, input int nbits, output logic [26:0] rd);
        rd = 27'h0000000;
        @(posedge clk);
        spi_select_n <= 1'b0;
        for (int i = 31; i > 31 - nbits; i--) begin
            @(posedge clk);
            spi_clk <= 1'b0;
            spi_data_in <= word[i];
            repeat (HALF) @(posedge clk);
            if (i < SSQ_DATA_BITS) rd[i] = pin_level;
            spi_clk <= 1'b1;
            repeat (HALF) @(posedge clk);
        end
        spi_clk <= 1'b0;
        spi_select_n <= 1'b1;
        spi_data_in <= ~spi_data_in;
        repeat (12) @(posedge clk);
    endtask : xfer
endmodule : ssq_host_model

// file: dv/synth_status_and_init_sequencer_tb.sv
// self-checking bench for the status and start-up sequencer
module synth_status_and_init_sequencer_tb
    import ssq_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [26:0] ID = 27'h0005A5A; // arbitrary value
    logic clk = 1'b0, resetn = 1'b0, pll_locked = 1'b0, cal_done = 1'b1;
    logic [4:0] ramp = 5'h00, ovc = 5'h00, cal_sub = 5'h00, sub, es;
    logic [1:0] cal_osc = 2'h0, osc, eo;
    logic spi_clk, spi_din, spi_sel_n, pin_o, pin_oe, ldo_en, pd, cal_start, man;
    logic [26:0] rd, d;
    int n_errors = 0, num_checks = 0, n_cal = 0;
    integer seed = 32'h99CD;
    logic [3:0] order [11] = '{4'h9, 4'h0, 4'h8, 4'h7, 4'h6, 4'h5, 4'h4, 4'h3, 4'h2, 4'h1, 4'h0};
    always #2 clk = ~clk;
    ssq_top #(.PART_ID_CODE(ID)) dut (.clk(clk), .resetn(resetn), .spi_clk(spi_clk),
        .spi_data_in(spi_din), .spi_select_n(spi_sel_n), .pll_locked(pll_locked),
        .ldo_rampup_ok(ramp), .ldo_overcurrent(ovc), .cal_done(cal_done),
        .cal_oscillator_choice(cal_osc), .cal_subband_setting(cal_sub),
        .lock_or_readback_pin_o(pin_o), .lock_or_readback_pin_oe(pin_oe), .ldo_enable(ldo_en),
        .core_powerdown(pd), .cal_start(cal_start), .manual_calibration_enable(man),
        .oscillator_choice(osc), .subband_setting(sub));
    ssq_host_model host (.clk(clk), .pin_o(pin_o), .pin_oe(pin_oe), .spi_clk(spi_clk),
        .spi_data_in(spi_din), .spi_select_n(spi_sel_n));
    // calibrator stand-in: busy three cycles, then a random result
    always begin
        @(posedge clk);
        if (cal_start === 1'b1) begin
            n_cal++;
            cal_done <= 1'b0;
            {cal_osc, cal_sub} <= 7'($random(seed));
            repeat (3) @(posedge clk);
            cal_done <= 1'b1;
        end
    end
    function automatic logic [26:0] exp_status(logic [1:0] o, logic [4:0] s);
        return {SSQ_RSVD_ZERO, ramp, ovc, pll_locked, o, s};
    endfunction : exp_status
    task automatic chk(input logic [26:0] got, input logic [26:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic acc(input logic r, input logic [3:0] a, input logic [26:0] v);
        host.xfer({r, a, v}, 32, rd);
    endtask : acc
    task automatic results;
        $display("checks %0d errors %0d", num_checks, n_errors);
        if (n_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : results
    initial begin
        repeat (60000) @(posedge clk);
        n_errors++;
        results();
    end
    initial begin
        repeat (5) @(posedge clk);
        resetn <= 1'b1;
        repeat (2) @(posedge clk);
        chk({25'h0, ldo_en, pd}, 27'h0000003);
        repeat (20) @(posedge clk);
        foreach (order[k]) begin
            d = (order[k] inside {4'h7, 4'h9}) ? 27'h0 : 27'($random(seed));
            d[26] = d[26] & (order[k] != 4'h1);
            acc(1'b0, order[k], d);
            if (k == 1) chk({pd, 26'(n_cal)}, 27'h0000001);
        end
        for (int i = 0; i < 8; i++) begin
            {ramp, ovc, pll_locked} <= 11'($random(seed));
            acc(1'b0, i[0] ? SSQ_MAIN_DIVIDER_REGISTER : SSQ_LOCK_AND_REGULATOR_STATUS,
                27'($random(seed)));
            for (int j = 0; j < 2; j++) begin
                acc(1'b1, SSQ_LOCK_AND_REGULATOR_STATUS, 27'h0);
                chk(rd, exp_status(cal_osc, cal_sub));
            end
        end
        host.xfer({5'h00, 27'h0}, 31, rd);
        acc(1'b1, SSQ_PART_IDENTIFICATION, 27'h0);
        chk(rd, ID);
        chk(27'(n_cal), 27'h0000006);
        {eo, es} = 7'($random(seed));
        acc(1'b0, SSQ_CALIBRATION_CONTROL_REGISTER, {eo, es, 20'h00000});
        acc(1'b0, SSQ_FRACTION_CONTROL_REGISTER, 27'h4000000);
        acc(1'b0, SSQ_MAIN_DIVIDER_REGISTER, 27'h0000000);
        acc(1'b1, SSQ_LOCK_AND_REGULATOR_STATUS, 27'h0);
        chk(rd, exp_status(eo, es));
        chk({man, 26'(n_cal)}, 27'h4000006);
        acc(1'b0, SSQ_PIN_CONTROL_REGISTER, 27'h0800000);
        for (int j = 0; j < 2; j++) begin
            pll_locked <= j[0];
            acc(1'b1, SSQ_LOCK_AND_REGULATOR_STATUS, 27'h0);
            chk(rd, {27{j[0]}});
        end
        acc(1'b0, SSQ_PIN_CONTROL_REGISTER, 27'h2000000);
        acc(1'b1, SSQ_LOCK_AND_REGULATOR_STATUS, 27'h0);
        chk(rd, 27'h7FFFFFF);
        chk({26'h0, pin_oe}, 27'h0000000);
        results();
    end
endmodule : synth_status_and_init_sequencer_tb
